// *** rtl/hcmb_mailbox.sv ***
// Host command mailbox with handshake, integrity counters and mode registers
`timescale 1ns/10ps
module hcmb_mailbox
   import hcmb_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // Host register port
   input  wire logic [6:0]  host_addr_in,
   input  wire logic        host_wr_in,
   input  wire logic        host_rd_in,
   input  wire logic [7:0]  host_wdata_in,
   output logic      [7:0]  host_rdata_out,
   // Data port byte strobe from the buffer path
   input  wire logic        port_byte_in,
   input  wire logic [7:0]  port_data_in,
   // On-chip CPU side
   input  wire logic [6:0]  cpu_addr_in,
   input  wire logic        cpu_wr_in,
   input  wire logic [7:0]  cpu_wdata_in,
   output logic      [7:0]  cpu_rdata_out,
   input  wire logic        cpu_done_in,
   input  wire logic        cpu_err_in,
   input  wire logic        cpu_err_clr_in,
   input  wire logic [15:0] cpu_status_in,
   input  wire logic        cpu_status_wr_in,
   output logic             cpu_irq_out,
   output logic             cpu_run_out,
   output logic             cmd_pending_out,
   // Buffer control outputs
   output logic             buffer_write_trigger_out,
   output logic             buffer_read_trigger_out,
   output logic             reg_access_mode_out,
   output logic             jpeg_table_select_out,
   output logic      [8:0]  jpeg_table_last_out,
   // By-pass timing counts
   output logic      [1:0]  cs_act_cyc_out,
   output logic      [1:0]  cs_inact_cyc_out,
   output logic      [1:0]  rd_delay_cyc_out,
   output logic      [1:0]  rd_short_cyc_out
);
   localparam int PAGE_BYTES = 80;

   logic [7:0]  main_page_reg   [PAGE_BYTES];
   logic [7:0]  mirror_page_reg [PAGE_BYTES];
   logic [7:0]  timing_reg;
   logic [15:0] checksum_reg;
   logic [23:0] count_reg;
   logic [7:0]  marker_reg;
   logic        cmd_ready_reg;
   logic        cmd_error_reg;
   logic        legacy_ready_reg;
   logic        legacy_error_reg;
   logic [15:0] status_reg;
   logic [7:0]  mode_reg;
   logic [7:0]  page_sel_reg;
   logic        irq_reg;
   hcmb_state_t state_reg;

   logic host_wr_reg;
   logic host_hs_wr;
   logic host_page_wr;
   logic sum_clear;
   logic cnt_clear;
   logic wr_trig;
   logic rd_trig;
   logic issue_set;

   hcmb_tim_if tim ();

   hcmb_tim_dec u_tim_dec (
      .tim (tim)
   );

   assign host_wr_reg  = host_wr_in;
   assign host_hs_wr   = host_wr_reg && (host_addr_in == HCMB_OFS_HANDSHAKE);
   // host may write main page only while main is mapped
   // page bit steers the shared range
   assign host_page_wr = host_wr_reg && (host_addr_in <= HCMB_PAGE_LAST)
                         && !page_sel_reg[HCMB_BIT_PAGE];
   assign wr_trig   = host_wr_reg && (host_addr_in == HCMB_OFS_BUF_CTRL)
                      && host_wdata_in[HCMB_BIT_WR_TRIG];
   assign rd_trig   = host_wr_reg && (host_addr_in == HCMB_OFS_BUF_CTRL)
                      && host_wdata_in[HCMB_BIT_RD_TRIG];
   assign sum_clear = (host_wr_reg && (host_addr_in == HCMB_OFS_CNT_CLR)
                      && host_wdata_in[HCMB_BIT_SUM_CLR]) || wr_trig || rd_trig;
   assign cnt_clear = (host_wr_reg && (host_addr_in == HCMB_OFS_CNT_CLR)
                      && host_wdata_in[HCMB_BIT_CNT_CLR]) || wr_trig || rd_trig;
   // issue bit is write-only, acts on write of 1
   assign issue_set = host_hs_wr && (host_wdata_in[HCMB_BIT_ISSUE_SET]
                      || host_wdata_in[HCMB_BIT_LEGACY_SET]);

   assign buffer_write_trigger_out = wr_trig;
   assign buffer_read_trigger_out  = rd_trig;

   // main page layout is plain byte storage, host side writes
   genvar gi;
   generate
      for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_page
         always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
               main_page_reg[gi] <= 8'h00;
            end else if (host_page_wr && (host_addr_in == 7'(gi))) begin
               main_page_reg[gi] <= host_wdata_in;
            end
         end
         // response bytes land in mirror page
         always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
               mirror_page_reg[gi] <= 8'h00;
            end else if (cpu_wr_in && (cpu_addr_in == 7'(gi))) begin
               mirror_page_reg[gi] <= cpu_wdata_in;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || sum_clear) begin
         checksum_reg <= 16'h0000;
      end else if (port_byte_in) begin
         checksum_reg <= checksum_reg + {8'h00, port_data_in};
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || cnt_clear) begin
         count_reg <= 24'h00_0000;
      end else if (port_byte_in) begin
         count_reg <= count_reg + 24'h00_0001;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         marker_reg <= HCMB_MARKER_RUN;
      end else if (host_wr_reg && (host_addr_in == HCMB_OFS_MARKER)) begin
         marker_reg <= host_wdata_in;
      end
   end
   assign cpu_run_out = (marker_reg == HCMB_MARKER_RUN);

   // device sets ready; set wins over host clear
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cmd_ready_reg    <= 1'b0;
         legacy_ready_reg <= 1'b0;
      end else begin
         if (cpu_done_in) begin
            cmd_ready_reg <= 1'b1;
         end else if (host_hs_wr && !host_wdata_in[HCMB_BIT_CMD_RDY]) begin
            cmd_ready_reg <= 1'b0;
         end
         if (cpu_done_in) begin
            legacy_ready_reg <= 1'b1;
         end else if (host_hs_wr && !host_wdata_in[HCMB_BIT_LEGACY_RDY]) begin
            legacy_ready_reg <= 1'b0;
         end
      end
   end

   // error flag set by CPU, read-only to host
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cmd_error_reg    <= 1'b0;
         legacy_error_reg <= 1'b0;
      end else if (cpu_err_in) begin
         cmd_error_reg    <= 1'b1;
         legacy_error_reg <= 1'b1;
      end else if (cpu_err_clr_in) begin
         cmd_error_reg    <= 1'b0;
         legacy_error_reg <= 1'b0;
      end
   end

   // device closes command: ready set and issue flag cleared together
   // host sets issue flag, device completion clears it
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_reg <= HCMB_ST_IDLE;
      end else begin
         unique case (state_reg)
            HCMB_ST_IDLE:  if (issue_set) state_reg <= HCMB_ST_ISSUE;
            HCMB_ST_ISSUE: if (cpu_done_in && !issue_set) state_reg <= HCMB_ST_DONE;
            HCMB_ST_DONE:  state_reg <= issue_set ? HCMB_ST_ISSUE : HCMB_ST_IDLE;
            default:       state_reg <= HCMB_ST_IDLE;
         endcase
      end
   end
   assign cmd_pending_out = (state_reg == HCMB_ST_ISSUE);

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= issue_set;
      end
   end
   assign cpu_irq_out = irq_reg;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         status_reg <= 16'h0000;
      end else if (cpu_status_wr_in) begin
         status_reg <= cpu_status_in;
      end
   end

   // mode bit and graphics reserved nibble
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         mode_reg     <= 8'h00;
         page_sel_reg <= 8'h00;
         timing_reg   <= HCMB_TIMING_RST;
      end else if (host_wr_reg) begin
         if (host_addr_in == HCMB_OFS_MODE) begin
            mode_reg <= host_wdata_in & HCMB_GRAPHICS_MASK;
         end
         if (host_addr_in == HCMB_OFS_PAGE_SEL) begin
            page_sel_reg <= host_wdata_in & HCMB_PAGE_SEL_MASK;
         end
         if (host_addr_in == HCMB_OFS_TIMING) begin
            timing_reg <= host_wdata_in;
         end
      end
   end
   assign reg_access_mode_out   = mode_reg[HCMB_BIT_MODE];
   assign jpeg_table_select_out = page_sel_reg[HCMB_BIT_JPEG_TBL];
   // table extent follows the select bit
   assign jpeg_table_last_out   = page_sel_reg[HCMB_BIT_JPEG_TBL] ? HCMB_QTAB_LAST
                                                                  : HCMB_HUFF_LAST;

   assign tim.select_delay_field = timing_reg[HCMB_TIM_CS_LSB +: 2];
   assign tim.read_strobe_delay  = timing_reg[HCMB_TIM_RDD_LSB +: 2];
   assign tim.read_front_shorten = timing_reg[HCMB_TIM_RDS_LSB +: 2];
   assign cs_act_cyc_out   = tim.cs_act_cyc;
   assign cs_inact_cyc_out = tim.cs_inact_cyc;
   assign rd_delay_cyc_out = tim.rd_delay_cyc;
   assign rd_short_cyc_out = tim.rd_short_cyc;

   // Host read data registered; issue bits read as zero being write-only
   // host sees mirror only when page bit is 1
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         host_rdata_out <= 8'h00;
      end else if (host_rd_in) begin
         if (host_addr_in <= HCMB_PAGE_LAST) begin
            host_rdata_out <= page_sel_reg[HCMB_BIT_PAGE] ? mirror_page_reg[host_addr_in]
                                                         : main_page_reg[host_addr_in];
         end else begin
            unique case (host_addr_in)
               HCMB_OFS_TIMING:    host_rdata_out <= timing_reg;
               HCMB_OFS_SUM_LO:    host_rdata_out <= checksum_reg[7:0];
               HCMB_OFS_SUM_HI:    host_rdata_out <= checksum_reg[15:8];
               HCMB_OFS_CNT_LO:    host_rdata_out <= count_reg[7:0];
               HCMB_OFS_CNT_MID:   host_rdata_out <= count_reg[15:8];
               HCMB_OFS_CNT_HI:    host_rdata_out <= count_reg[23:16];
               HCMB_OFS_MARKER:    host_rdata_out <= marker_reg;
               HCMB_OFS_HANDSHAKE: host_rdata_out <= {2'b00, cmd_error_reg, 1'b0,
                                                      legacy_error_reg, 1'b0,
                                                      cmd_ready_reg, legacy_ready_reg};
               HCMB_OFS_STAT_LO:   host_rdata_out <= status_reg[7:0];
               HCMB_OFS_STAT_HI:   host_rdata_out <= status_reg[15:8];
               HCMB_OFS_MODE:      host_rdata_out <= mode_reg;
               HCMB_OFS_PAGE_SEL:  host_rdata_out <= page_sel_reg;
               default:            host_rdata_out <= 8'h00;
            endcase
         end
      end
   end

   // CPU read: main page up to and including HCMB_PAGE_LAST, zero elsewhere
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cpu_rdata_out <= 8'h00;
      end else if (cpu_addr_in <= HCMB_PAGE_LAST) begin
         cpu_rdata_out <= main_page_reg[cpu_addr_in];
      end else begin
         cpu_rdata_out <= 8'h00;
      end
   end
endmodule : hcmb_mailbox

// *** rtl/hcmb_pkg.sv ***
// Constants and types shared by the host command mailbox design
package hcmb_pkg;
   // Host register offsets
   localparam logic [6:0] HCMB_PAGE_LAST      = 7'h4f;
   localparam logic [6:0] HCMB_OFS_TIMING     = 7'h72;
   localparam logic [6:0] HCMB_OFS_BUF_CTRL   = 7'h73;
   localparam logic [6:0] HCMB_OFS_CNT_CLR    = 7'h74;
   localparam logic [6:0] HCMB_OFS_SUM_LO     = 7'h75;
   localparam logic [6:0] HCMB_OFS_SUM_HI     = 7'h76;
   localparam logic [6:0] HCMB_OFS_CNT_LO     = 7'h77;
   localparam logic [6:0] HCMB_OFS_CNT_MID    = 7'h78;
   localparam logic [6:0] HCMB_OFS_CNT_HI     = 7'h79;
   localparam logic [6:0] HCMB_OFS_MARKER     = 7'h7a;
   localparam logic [6:0] HCMB_OFS_HANDSHAKE  = 7'h7b;
   localparam logic [6:0] HCMB_OFS_STAT_LO    = 7'h7c;
   localparam logic [6:0] HCMB_OFS_STAT_HI    = 7'h7d;
   localparam logic [6:0] HCMB_OFS_MODE       = 7'h7e;
   localparam logic [6:0] HCMB_OFS_PAGE_SEL   = 7'h7f;
   // Field positions
   localparam int HCMB_BIT_LEGACY_RDY  = 0;
   localparam int HCMB_BIT_CMD_RDY     = 1;
   localparam int HCMB_BIT_LEGACY_ERR  = 3;
   localparam int HCMB_BIT_CMD_ERR     = 5;
   localparam int HCMB_BIT_LEGACY_SET  = 6;
   localparam int HCMB_BIT_ISSUE_SET   = 7;
   localparam int HCMB_BIT_WR_TRIG     = 0;
   localparam int HCMB_BIT_RD_TRIG     = 1;
   localparam int HCMB_BIT_SUM_CLR     = 0;
   localparam int HCMB_BIT_CNT_CLR     = 1;
   localparam int HCMB_BIT_MODE        = 0;
   localparam int HCMB_BIT_PAGE        = 5;
   localparam int HCMB_BIT_JPEG_TBL    = 6;
   localparam int HCMB_TIM_CS_LSB      = 2;
   localparam int HCMB_TIM_RDD_LSB     = 4;
   localparam int HCMB_TIM_RDS_LSB     = 6;
   // Reset values and write masks
   localparam logic [7:0] HCMB_MARKER_RUN     = 8'h5a;
   localparam logic [7:0] HCMB_TIMING_RST     = 8'h00;
   localparam logic [7:0] HCMB_GRAPHICS_MASK  = 8'hf1;
   localparam logic [7:0] HCMB_PAGE_SEL_MASK  = 8'h60;
   // Table sizes
   localparam logic [8:0] HCMB_HUFF_LAST      = 9'h1ff;
   localparam logic [8:0] HCMB_QTAB_LAST      = 9'h07f;
   // Pulse timing, figures in ns
   localparam int HCMB_CLK_NS = 10;
   localparam int HCMB_T15_NS = 15;
   localparam int HCMB_T10_NS = 10;
   localparam int HCMB_T5_NS  = 5;
   localparam logic [1:0] HCMB_CYC_15 = 2'((HCMB_T15_NS + HCMB_CLK_NS - 1) / HCMB_CLK_NS);
   localparam logic [1:0] HCMB_CYC_10 = 2'((HCMB_T10_NS + HCMB_CLK_NS - 1) / HCMB_CLK_NS);
   localparam logic [1:0] HCMB_CYC_5  = 2'((HCMB_T5_NS + HCMB_CLK_NS - 1) / HCMB_CLK_NS);
   localparam logic [1:0] HCMB_CYC_0  = 2'h0;
   typedef enum logic [1:0] {
      HCMB_ST_IDLE  = 2'b00,
      HCMB_ST_ISSUE = 2'b01,
      HCMB_ST_DONE  = 2'b11
   } hcmb_state_t;
endpackage : hcmb_pkg

// *** rtl/hcmb_tim_if.sv ***
// Carrier of the by-pass timing selections and resulting delay counts
`timescale 1ns/10ps
interface hcmb_tim_if;
   logic [1:0] select_delay_field;
   logic [1:0] read_strobe_delay;
   logic [1:0] read_front_shorten;
   logic [1:0] cs_act_cyc;
   logic [1:0] cs_inact_cyc;
   logic [1:0] rd_delay_cyc;
   logic [1:0] rd_short_cyc;
   modport ctrl (output select_delay_field, read_strobe_delay, read_front_shorten,
                 input cs_act_cyc, cs_inact_cyc, rd_delay_cyc, rd_short_cyc);
   modport dec  (input select_delay_field, read_strobe_delay, read_front_shorten,
                 output cs_act_cyc, cs_inact_cyc, rd_delay_cyc, rd_short_cyc);
endinterface : hcmb_tim_if

// *** rtl/hcmb_tim_dec.sv ***
// Decoder from by-pass timing fields to clock-cycle counts
`timescale 1ns/10ps
module hcmb_tim_dec
   import hcmb_pkg::*;
(
   hcmb_tim_if.dec tim
);
   always_comb begin
      unique case (tim.select_delay_field)
         2'h0: begin
            tim.cs_act_cyc   = HCMB_CYC_10;
            tim.cs_inact_cyc = HCMB_CYC_10;
         end
         2'h1: begin
            tim.cs_act_cyc   = HCMB_CYC_10;
            tim.cs_inact_cyc = HCMB_CYC_5;
         end
         2'h2: begin
            tim.cs_act_cyc   = HCMB_CYC_10;
            tim.cs_inact_cyc = HCMB_CYC_0;
         end
         2'h3: begin
            tim.cs_act_cyc   = HCMB_CYC_0;
            tim.cs_inact_cyc = HCMB_CYC_0;
         end
      endcase
   end

   always_comb begin
      unique case (tim.read_strobe_delay)
         2'h0: tim.rd_delay_cyc = HCMB_CYC_15;
         2'h1: tim.rd_delay_cyc = HCMB_CYC_10;
         2'h2: tim.rd_delay_cyc = HCMB_CYC_5;
         2'h3: tim.rd_delay_cyc = HCMB_CYC_0;
      endcase
   end

   always_comb begin
      unique case (tim.read_front_shorten)
         2'h0: tim.rd_short_cyc = HCMB_CYC_15;
         2'h1: tim.rd_short_cyc = HCMB_CYC_10;
         2'h2: tim.rd_short_cyc = HCMB_CYC_5;
         2'h3: tim.rd_short_cyc = HCMB_CYC_0;
      endcase
   end
endmodule : hcmb_tim_dec

// *** sim/hcmb_mailbox_assertions.sv ***
// Port-level assertions for the host command mailbox
`timescale 1ns/10ps
module hcmb_mailbox_chk
   import hcmb_pkg::*;
(
   input wire logic       ref_clk_in,
   input wire logic       rst_in,
   input wire logic [6:0] host_addr_in,
   input wire logic       host_wr_in,
   input wire logic [7:0] host_wdata_in,
   input wire logic       cpu_done_in,
   input wire logic       cpu_irq_out,
   input wire logic       cpu_run_out,
   input wire logic       cmd_pending_out,
   input wire logic       buffer_write_trigger_out,
   input wire logic       buffer_read_trigger_out,
   input wire logic       reg_access_mode_out,
   input wire logic       jpeg_table_select_out,
   input wire logic [8:0] jpeg_table_last_out,
   input wire logic [1:0] cs_act_cyc_out,
   input wire logic [1:0] cs_inact_cyc_out,
   input wire logic [1:0] rd_delay_cyc_out,
   input wire logic [1:0] rd_short_cyc_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   logic issue_wr;
   logic tim_wr;
   assign issue_wr = host_wr_in && host_addr_in == HCMB_OFS_HANDSHAKE &&
                     (host_wdata_in[HCMB_BIT_ISSUE_SET] || host_wdata_in[HCMB_BIT_LEGACY_SET]);
   assign tim_wr = host_wr_in && host_addr_in == HCMB_OFS_TIMING;

   chk_irq_after_issue:
      assert property (issue_wr |=> cpu_irq_out) else $error("no cpu interrupt after issue");
   chk_irq_has_cause:
      assert property (cpu_irq_out |-> $past(issue_wr)) else $error("stray cpu interrupt");
   chk_irq_one_cycle:
      assert property (cpu_irq_out && !issue_wr |=> !cpu_irq_out)
         else $error("cpu interrupt too long");
   chk_pending_on_issue:
      assert property (issue_wr |=> cmd_pending_out)
         else $error("pending not set by issue");
   chk_pending_on_done:
      assert property (cpu_done_in && !issue_wr |=> !cmd_pending_out)
         else $error("pending not ended by completion");
   chk_run_follows_marker:
      assert property (host_wr_in && host_addr_in == HCMB_OFS_MARKER |=>
                       cpu_run_out == ($past(host_wdata_in) == HCMB_MARKER_RUN))
         else $error("cpu run does not follow marker");
   chk_trigger_match:
      assert property (host_wr_in && host_addr_in == HCMB_OFS_BUF_CTRL |->
                       buffer_write_trigger_out == host_wdata_in[HCMB_BIT_WR_TRIG] &&
                       buffer_read_trigger_out == host_wdata_in[HCMB_BIT_RD_TRIG])
         else $error("buffer trigger mismatch");
   chk_trigger_cause:
      assert property (buffer_write_trigger_out || buffer_read_trigger_out |->
                       host_wr_in && host_addr_in == HCMB_OFS_BUF_CTRL)
         else $error("buffer trigger without write");
   chk_cs_timing:
      assert property (tim_wr |=> cs_act_cyc_out == ($past(host_wdata_in[3:2]) == 2'd3 ? 2'd0 : 2'd1)
                       && cs_inact_cyc_out == ($past(host_wdata_in[3]) ? 2'd0 : 2'd1))
         else $error("chip-select timing counts wrong");
   chk_rd_delay:
      assert property (tim_wr |=> rd_delay_cyc_out == ($past(host_wdata_in[5:4]) == 2'd0 ? 2'd2 :
                       $past(host_wdata_in[5:4]) == 2'd3 ? 2'd0 : 2'd1))
         else $error("read delay count wrong");
   chk_rd_short:
      assert property (tim_wr |=> rd_short_cyc_out == ($past(host_wdata_in[7:6]) == 2'd0 ? 2'd2 :
                       $past(host_wdata_in[7:6]) == 2'd3 ? 2'd0 : 2'd1))
         else $error("read shorten count wrong");
   chk_mode_bit:
      assert property (host_wr_in && host_addr_in == HCMB_OFS_MODE |=>
                       reg_access_mode_out == $past(host_wdata_in[HCMB_BIT_MODE]))
         else $error("access mode level wrong");
   chk_table_pick:
      assert property (host_wr_in && host_addr_in == HCMB_OFS_PAGE_SEL |=>
                       jpeg_table_select_out == $past(host_wdata_in[HCMB_BIT_JPEG_TBL]) &&
                       jpeg_table_last_out == (jpeg_table_select_out ? HCMB_QTAB_LAST : HCMB_HUFF_LAST))
         else $error("table select wrong");
endmodule : hcmb_mailbox_chk

bind hcmb_mailbox hcmb_mailbox_chk u_chk (.ref_clk_in, .rst_in, .host_addr_in, .host_wr_in,
   .host_wdata_in, .cpu_done_in, .cpu_irq_out, .cpu_run_out, .cmd_pending_out,
   .buffer_write_trigger_out, .buffer_read_trigger_out, .reg_access_mode_out,
   .jpeg_table_select_out, .jpeg_table_last_out, .cs_act_cyc_out, .cs_inact_cyc_out,
   .rd_delay_cyc_out, .rd_short_cyc_out);

// *** sim/hcmb_cpu_model.sv ***
// Behavioural on-chip CPU that answers mailbox commands
`timescale 1ns/10ps
module hcmb_cpu_model
#(
   parameter int         WORK_CYC = 4,
   parameter logic [7:0] FAIL_ID  = 8'hee
)
(
   input  wire logic       ref_clk_in,
   input  wire logic       cpu_irq_in,
   input  wire logic [7:0] main_byte_in,
   output logic      [6:0] cpu_addr_out,
   output logic            cpu_wr_out,
   output logic      [7:0] cpu_wdata_out,
   output logic            cpu_done_out,
   output logic            cpu_err_out
);
   logic [7:0] cmd_lo;
   initial begin
      cpu_addr_out = 7'h00;
      cpu_wr_out = 1'b0;
      cpu_wdata_out = 8'h00;
      cpu_done_out = 1'b0;
      cpu_err_out = 1'b0;
      forever begin
         @(posedge ref_clk_in);
         if (cpu_irq_in === 1'b1) begin
            #1;
            cpu_addr_out = 7'h00;
            @(posedge ref_clk_in);
            #1;
            cmd_lo = main_byte_in;
            repeat (WORK_CYC) @(posedge ref_clk_in);
            #1;
            // response lands in mirror before ready
            cpu_wr_out = 1'b1;
            cpu_wdata_out = ~cmd_lo;
            @(posedge ref_clk_in);
            #1;
            cpu_wr_out = 1'b0;
            // Stale data is inverted so nothing relies on a held bus
            cpu_wdata_out = ~cpu_wdata_out;
            // completion, with error for the failing command
            cpu_done_out = 1'b1;
            cpu_err_out = (cmd_lo == FAIL_ID);
            @(posedge ref_clk_in);
            #1;
            cpu_done_out = 1'b0;
            cpu_err_out = 1'b0;
         end
      end
   end
endmodule : hcmb_cpu_model

// *** sim/hcmb_mailbox_tb.sv ***
// Self-checking bench for the host command mailbox
`timescale 1ns/10ps
module hcmb_mailbox_tb;
   import hcmb_pkg::*;
   logic        ref_clk_in, rst_in, host_wr_in, host_rd_in, port_byte_in, cpu_wr_in;
   logic        cpu_done_in, cpu_err_in, cpu_err_clr_in, cpu_status_wr_in, cpu_irq_out;
   logic        cpu_run_out, cmd_pending_out, buffer_write_trigger_out, buffer_read_trigger_out;
   logic        reg_access_mode_out, jpeg_table_select_out;
   logic [6:0]  host_addr_in, cpu_addr_in;
   logic [7:0]  host_wdata_in, host_rdata_out, port_data_in, cpu_wdata_in, cpu_rdata_out;
   logic [15:0] cpu_status_in;
   logic [8:0]  jpeg_table_last_out;
   logic [1:0]  cs_act_cyc_out, cs_inact_cyc_out, rd_delay_cyc_out, rd_short_cyc_out;
   int          n_fail, tests_run, v;

   hcmb_mailbox uut (.ref_clk_in, .rst_in, .host_addr_in, .host_wr_in, .host_rd_in,
      .host_wdata_in, .host_rdata_out, .port_byte_in, .port_data_in, .cpu_addr_in, .cpu_wr_in,
      .cpu_wdata_in, .cpu_rdata_out, .cpu_done_in, .cpu_err_in, .cpu_err_clr_in, .cpu_status_in,
      .cpu_status_wr_in, .cpu_irq_out, .cpu_run_out, .cmd_pending_out, .buffer_write_trigger_out,
      .buffer_read_trigger_out, .reg_access_mode_out, .jpeg_table_select_out,
      .jpeg_table_last_out, .cs_act_cyc_out, .cs_inact_cyc_out, .rd_delay_cyc_out,
      .rd_short_cyc_out);
   hcmb_cpu_model u_cpu (.ref_clk_in, .cpu_irq_in(cpu_irq_out), .main_byte_in(cpu_rdata_out),
      .cpu_addr_out(cpu_addr_in), .cpu_wr_out(cpu_wr_in), .cpu_wdata_out(cpu_wdata_in),
      .cpu_done_out(cpu_done_in), .cpu_err_out(cpu_err_in));

   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic host_wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      #1;
      host_addr_in = a;
      host_wdata_in = d;
      host_wr_in = 1'b1;
      @(posedge ref_clk_in);
      #1;
      host_wr_in = 1'b0;
      host_wdata_in = ~d;
   endtask : host_wr
   task automatic host_rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      #1;
      host_addr_in = a;
      host_rd_in = 1'b1;
      @(posedge ref_clk_in);
      #1;
      host_rd_in = 1'b0;
      d = host_rdata_out;
   endtask : host_rd
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] mask, input logic [7:0] exp);
      logic [7:0] d;
      host_rd(a, d);
      check($sformatf("reg %h", a), d & mask, exp);
   endtask : rd_chk
   task automatic send_bytes(input int n, input logic [7:0] d);
      repeat (n) begin
         @(posedge ref_clk_in);
         #1;
         port_byte_in = 1'b1;
         port_data_in = d;
         @(posedge ref_clk_in);
         #1;
         port_byte_in = 1'b0;
         port_data_in = ~d;
      end
   endtask : send_bytes
   task automatic run_cmd(input logic [7:0] id_lo);
      logic [7:0] d;
      int i;
      host_wr(HCMB_OFS_PAGE_SEL, 8'h00);
      host_wr(7'h00, id_lo);
      host_wr(7'h01, 8'h12);
      host_wr(7'h02, 8'h01);
      host_wr(7'h03, 8'h00);
      host_wr(7'h04, 8'h5c);
      host_wr(HCMB_OFS_HANDSHAKE, 8'h80);
      check("pending", cmd_pending_out, 1'b1);
      d = 8'h00;
      for (i = 0; i < 50 && d[HCMB_BIT_CMD_RDY] !== 1'b1; i++) host_rd(HCMB_OFS_HANDSHAKE, d);
      check("ready", d[HCMB_BIT_CMD_RDY], 1'b1);
      check("pending end", cmd_pending_out, 1'b0);
   endtask : run_cmd
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (5000) @(posedge ref_clk_in);
      n_fail++;
      report_and_stop();
   end

   initial begin
      {host_wr_in, host_rd_in, port_byte_in, cpu_err_clr_in, cpu_status_wr_in} = '0;
      host_addr_in = 7'h00;
      host_wdata_in = 8'h00;
      port_data_in = 8'h00;
      cpu_status_in = 16'h0000;
      n_fail = 0;
      tests_run = 0;
      rst_in = 1'b1;
      repeat (10) @(posedge ref_clk_in);
      #1;
      rst_in = 1'b0;
      check("run", cpu_run_out, 1'b1);
      rd_chk(HCMB_OFS_MARKER, 8'hff, 8'h5a);
      check("table last", jpeg_table_last_out, HCMB_HUFF_LAST);
      for (v = 0; v < 4; v++) begin
         host_wr(HCMB_OFS_TIMING, {v[1:0], v[1:0], v[1:0], 2'b00});
         check("cs act", cs_act_cyc_out, v == 3 ? 2'd0 : 2'd1);
         check("cs inact", cs_inact_cyc_out, v < 2 ? 2'd1 : 2'd0);
         check("rd delay", rd_delay_cyc_out, v == 0 ? 2'd2 : v == 3 ? 2'd0 : 2'd1);
         check("rd short", rd_short_cyc_out, v == 0 ? 2'd2 : v == 3 ? 2'd0 : 2'd1);
      end
      host_wr(HCMB_OFS_MARKER, 8'h00);
      check("run", cpu_run_out, 1'b0);
      // marker put back to its power-on value
      host_wr(HCMB_OFS_MARKER, 8'h5a);
      check("run", cpu_run_out, 1'b1);
      run_cmd(8'h34);
      host_wr(HCMB_OFS_HANDSHAKE, 8'h00);
      rd_chk(HCMB_OFS_HANDSHAKE, 8'h22, 8'h00);
      host_wr(HCMB_OFS_PAGE_SEL, 8'h20);
      rd_chk(7'h00, 8'hff, 8'hcb);
      host_wr(7'h00, 8'h99);
      host_wr(HCMB_OFS_PAGE_SEL, 8'h00);
      rd_chk(7'h00, 8'hff, 8'h34);
      rd_chk(7'h01, 8'hff, 8'h12);
      rd_chk(7'h04, 8'hff, 8'h5c);
      run_cmd(8'hee);
      rd_chk(HCMB_OFS_HANDSHAKE, 8'h22, 8'h22);
      host_wr(HCMB_OFS_HANDSHAKE, 8'h00);
      rd_chk(HCMB_OFS_HANDSHAKE, 8'h22, 8'h20);
      @(posedge ref_clk_in);
      #1;
      cpu_err_clr_in = 1'b1;
      cpu_status_in = 16'hbeef;
      cpu_status_wr_in = 1'b1;
      @(posedge ref_clk_in);
      #1;
      cpu_err_clr_in = 1'b0;
      cpu_status_wr_in = 1'b0;
      rd_chk(HCMB_OFS_HANDSHAKE, 8'h22, 8'h00);
      rd_chk(HCMB_OFS_STAT_LO, 8'hff, 8'hef);
      rd_chk(HCMB_OFS_STAT_HI, 8'hff, 8'hbe);
      host_wr(HCMB_OFS_BUF_CTRL, 8'h01);
      send_bytes(258, 8'hff);
      rd_chk(HCMB_OFS_SUM_LO, 8'hff, 8'hfe);
      rd_chk(HCMB_OFS_SUM_HI, 8'hff, 8'h00);
      rd_chk(HCMB_OFS_CNT_LO, 8'hff, 8'h02);
      rd_chk(HCMB_OFS_CNT_MID, 8'hff, 8'h01);
      rd_chk(HCMB_OFS_CNT_HI, 8'hff, 8'h00);
      host_wr(HCMB_OFS_CNT_CLR, 8'h01);
      host_wr(HCMB_OFS_SUM_LO, 8'haa);
      rd_chk(HCMB_OFS_SUM_LO, 8'hff, 8'h00);
      rd_chk(HCMB_OFS_CNT_LO, 8'hff, 8'h02);
      host_wr(HCMB_OFS_CNT_CLR, 8'h02);
      rd_chk(HCMB_OFS_CNT_MID, 8'hff, 8'h00);
      send_bytes(1, 8'h10);
      rd_chk(HCMB_OFS_SUM_LO, 8'hff, 8'h10);
      host_wr(HCMB_OFS_BUF_CTRL, 8'h02);
      rd_chk(HCMB_OFS_SUM_LO, 8'hff, 8'h00);
      rd_chk(HCMB_OFS_CNT_LO, 8'hff, 8'h00);
      host_wr(HCMB_OFS_MODE, 8'hff);
      check("mode", reg_access_mode_out, 1'b1);
      rd_chk(HCMB_OFS_MODE, 8'hff, 8'hf1);
      host_wr(HCMB_OFS_MODE, 8'h00);
      check("mode", reg_access_mode_out, 1'b0);
      host_wr(HCMB_OFS_PAGE_SEL, 8'h40);
      check("table sel", jpeg_table_select_out, 1'b1);
      check("table last", jpeg_table_last_out, HCMB_QTAB_LAST);
      rd_chk(HCMB_OFS_PAGE_SEL, 8'hff, 8'h40);
      rd_chk(7'h50, 8'hff, 8'h00);
      report_and_stop();
   end
endmodule : hcmb_mailbox_tb
